// ---- core/fan_pwm_config_status_regs.sv ----
// Behaviour
// - Local overtemperature sets status bit 6; read clears; no reassert while persisting.
// - Overtemperature pin pulled low sets status bit 7; read clears it.
// - Overtemperature pin held low forces full fan duty.
// - Fraction register returns remote bits in 2:0 and local bits in 7:6.
// - Spin-up code selects 200ms to 8s; reset code gives 2s.
// - Frequency code selects 11.7 to 93.5 Hz; reset gives 31.25 Hz.
// - Speed range code gives divisor N of 1, 2, 4 or 8.
// - Low nibble is normal speed in software mode, floor in automatic mode.
// - Spin-up disable bit skips the spin-up phase.
// - Ramp code selects rate 1, 2, 4 or 8 per PWM period.
// - Converter sample rate code, 87.5 Hz to 11.2 kHz, reset 1.4 kHz.
// - Output filtering (ramping) applies only while filter enable is one.
// - Power-on values 5d, 05, 50; status and fraction start at zero.
// - Control select one runs automatic control, zero software control.
// - Output low for full duty unless polarity invert is one.
`timescale 1ns/10ps
`include "fan_regs_map.svh"

module fan_pwm_config_status_regs #(
    parameter int CLK_HZ = 20_000_000
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Register port from two-wire front end
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Measurement side
    input  wire logic       local_over_limit,
    input  wire logic [2:0] remote_frac,
    input  wire logic [1:0] local_frac,
    input  wire logic [3:0] auto_duty,
    // Overtemperature pin, open drain input only here
    input  wire logic       therm_n_in,
    // Other configuration
    input  wire logic       auto_control_select,
    input  wire logic       pwm_invert,
    // Fan side
    output logic            pwm_out,
    output logic [3:0]      speed_range_n,
    output logic [2:0]      adc_rate_sel
);
    localparam int MS_CYC = CLK_HZ / `MS_PER_SEC;

    function automatic logic [23:0] slot_len(input logic [2:0] code);
        longint chz;
        case (code)
            3'h0:    chz = `FREQ_CHZ_0;
            3'h1:    chz = `FREQ_CHZ_1;
            3'h2:    chz = `FREQ_CHZ_2;
            3'h3:    chz = `FREQ_CHZ_3;
            3'h4:    chz = `FREQ_CHZ_4;
            3'h5:    chz = `FREQ_CHZ_5;
            3'h6:    chz = `FREQ_CHZ_6;
            default: chz = `FREQ_CHZ_7;
        endcase
        slot_len = 24'((longint'(CLK_HZ) * `CENTI_PER_UNIT) / (chz * `PWM_SLOTS));
    endfunction

    function automatic logic [13:0] spin_ms(input logic [2:0] code);
        case (code)
            3'h0:    spin_ms = `SPIN_MS_0;
            3'h1:    spin_ms = `SPIN_MS_1;
            3'h2:    spin_ms = `SPIN_MS_2;
            3'h3:    spin_ms = `SPIN_MS_3;
            3'h4:    spin_ms = `SPIN_MS_4;
            3'h5:    spin_ms = `SPIN_MS_5;
            3'h6:    spin_ms = `SPIN_MS_6;
            default: spin_ms = `SPIN_MS_7;
        endcase
    endfunction

    // Register state
    logic [7:0] stat_q, stat_d;
    logic [7:0] timing_q, timing_d;
    logic [7:0] floor_q, floor_d;
    logic [7:0] filt_q, filt_d;
    logic [7:0] rdata_q, rdata_d;
    logic       therm_s1_q, therm_s2_q, therm_prev_q, local_prev_q;
    logic [3:0] range_q, range_d;
    logic [2:0] adc_q, adc_d;

    // Drive state
    fan_pkg::spin_state_t spin_q, spin_d;
    logic [3:0]  duty_q, duty_d;
    logic [31:0] ms_cnt_q, ms_cnt_d;
    logic [13:0] spin_cnt_q, spin_cnt_d;
    logic        pwm_q, pwm_d;
    logic [3:0]  target, drive_duty, step;
    logic        active, period_end, therm_low;

    assign therm_low = ~therm_s2_q;

    always_comb begin
        stat_d   = stat_q;
        timing_d = timing_q;
        floor_d  = floor_q;
        filt_d   = filt_q;
        rdata_d  = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_THERMAL_STATUS_B: rdata_d = stat_q;
                `ADDR_TEMP_FRACTION:    rdata_d = {local_frac, 3'h0, remote_frac};
                `ADDR_FAN_DRIVE_TIMING: rdata_d = timing_q;
                `ADDR_FAN_FLOOR_SPEED:  rdata_d = floor_q;
                `ADDR_FAN_FILTER_CTRL:  rdata_d = filt_q;
                default:                rdata_d = 8'h00;
            endcase
            if (reg_addr == `ADDR_THERMAL_STATUS_B) begin
                stat_d = 8'h00;
            end
        end
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_FAN_DRIVE_TIMING: timing_d = reg_wdata & `MASK_FAN_DRIVE_TIMING;
                `ADDR_FAN_FLOOR_SPEED:  floor_d  = reg_wdata & `MASK_FAN_FLOOR_SPEED;
                `ADDR_FAN_FILTER_CTRL:  filt_d   = reg_wdata & `MASK_FAN_FILTER_CTRL;
                default:                ;
            endcase
        end
        // Set wins over read clear
        if (local_over_limit && !local_prev_q) begin
            stat_d[`STAT_LOCAL_OT_BIT] = 1'b1;
        end
        if (therm_low && therm_prev_q) begin
            stat_d[`STAT_THERM_PIN_BIT] = 1'b1;
        end
        range_d = 4'h1 << timing_q[`TIM_RANGE_LSB +: 2];
        adc_d   = filt_q[`FLT_ADC_LSB +: 3];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_q       <= `RST_THERMAL_STATUS_B;
            timing_q     <= `RST_FAN_DRIVE_TIMING;
            floor_q      <= `RST_FAN_FLOOR_SPEED;
            filt_q       <= `RST_FAN_FILTER_CTRL;
            rdata_q      <= 8'h00;
            therm_s1_q   <= 1'b1;
            therm_s2_q   <= 1'b1;
            therm_prev_q <= 1'b1;
            local_prev_q <= 1'b0;
            range_q      <= 4'h1;
            adc_q        <= 3'h0;
        end else begin
            stat_q       <= stat_d;
            timing_q     <= timing_d;
            floor_q      <= floor_d;
            filt_q       <= filt_d;
            rdata_q      <= rdata_d;
            therm_s1_q   <= therm_n_in;
            therm_s2_q   <= therm_s1_q;
            therm_prev_q <= therm_s2_q;
            local_prev_q <= local_over_limit;
            range_q      <= range_d;
            adc_q        <= adc_d;
        end
    end

    // Target duty selection
    always_comb begin
        if (therm_low) begin
            target = `DUTY_FULL;
        end else if (auto_control_select) begin
            target = (auto_duty > floor_q[3:0]) ? auto_duty : floor_q[3:0];
        end else begin
            target = floor_q[3:0];
        end
        step = 4'h1 << filt_q[`FLT_RAMP_LSB +: 2];
    end

    // Spin-up and ramp
    always_comb begin
        spin_d     = spin_q;
        duty_d     = duty_q;
        ms_cnt_d   = ms_cnt_q;
        spin_cnt_d = spin_cnt_q;
        if (!filt_q[`FLT_ENABLE_BIT]) begin
            duty_d = target;
        end else if (period_end) begin
            if (duty_q < target) begin
                duty_d = (5'(target) - 5'(duty_q) > 5'(step)) ? duty_q + step : target;
            end else if (duty_q > target) begin
                duty_d = (5'(duty_q) - 5'(target) > 5'(step)) ? duty_q - step : target;
            end
        end
        case (spin_q)
            fan_pkg::SPIN_STOPPED: begin
                if (target != 4'h0) begin
                    if (filt_q[`FLT_SPIN_DIS_BIT]) begin
                        spin_d = fan_pkg::SPIN_RUN;
                    end else begin
                        spin_d     = fan_pkg::SPIN_KICK;
                        ms_cnt_d   = 32'h0;
                        spin_cnt_d = spin_ms(timing_q[`TIM_SPINUP_LSB +: 3]);
                    end
                end
            end
            fan_pkg::SPIN_KICK: begin
                if (ms_cnt_q >= 32'(MS_CYC - 1)) begin
                    ms_cnt_d   = 32'h0;
                    spin_cnt_d = spin_cnt_q - 14'd1;
                    if (spin_cnt_q <= 14'd1) begin
                        spin_d = fan_pkg::SPIN_RUN;
                    end
                end else begin
                    ms_cnt_d = ms_cnt_q + 32'h1;
                end
                if (filt_q[`FLT_SPIN_DIS_BIT]) begin
                    spin_d = fan_pkg::SPIN_RUN;
                end
            end
            fan_pkg::SPIN_RUN: begin
                if (target == 4'h0 && duty_q == 4'h0) begin
                    spin_d = fan_pkg::SPIN_STOPPED;
                end
            end
            default: spin_d = fan_pkg::SPIN_STOPPED;
        endcase
        drive_duty = (spin_q == fan_pkg::SPIN_KICK) ? `DUTY_FULL : duty_q;
        pwm_d      = pwm_invert ? active : ~active;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            spin_q     <= fan_pkg::SPIN_STOPPED;
            duty_q     <= 4'h0;
            ms_cnt_q   <= 32'h0;
            spin_cnt_q <= 14'd0;
            pwm_q      <= 1'b1;
        end else begin
            spin_q     <= spin_d;
            duty_q     <= duty_d;
            ms_cnt_q   <= ms_cnt_d;
            spin_cnt_q <= spin_cnt_d;
            pwm_q      <= pwm_d;
        end
    end

    pwm_slot_gen #(
        .CNT_W (24)
    ) u_slot (
        .clk         (clk),
        .rst         (rst),
        .slot_cycles (slot_len(timing_q[`TIM_FREQ_LSB +: 3])),
        .duty        (drive_duty),
        .active      (active),
        .period_end  (period_end)
    );

    assign reg_rdata     = rdata_q;
    assign pwm_out       = pwm_q;
    assign speed_range_n = range_q;
    assign adc_rate_sel  = adc_q;
endmodule

// ---- core/fan_regs_map.svh ----
`ifndef FAN_REGS_MAP_SVH
`define FAN_REGS_MAP_SVH

// Register offsets
`define ADDR_THERMAL_STATUS_B 8'h03
`define ADDR_TEMP_FRACTION    8'h06
`define ADDR_FAN_DRIVE_TIMING 8'h20
`define ADDR_FAN_FLOOR_SPEED  8'h22
`define ADDR_FAN_FILTER_CTRL  8'h23

// Reset values
`define RST_THERMAL_STATUS_B  8'h00
`define RST_FAN_DRIVE_TIMING  8'h5d
`define RST_FAN_FLOOR_SPEED   8'h05
`define RST_FAN_FILTER_CTRL   8'h50

// Status fields
`define STAT_LOCAL_OT_BIT     6
`define STAT_THERM_PIN_BIT    7

// Drive timing fields
`define TIM_SPINUP_LSB        0
`define TIM_FREQ_LSB          3
`define TIM_RANGE_LSB         6

// Filter fields
`define FLT_ENABLE_BIT        0
`define FLT_ADC_LSB           2
`define FLT_RAMP_LSB          5
`define FLT_SPIN_DIS_BIT      7

// Writable masks
`define MASK_FAN_DRIVE_TIMING 8'hff
`define MASK_FAN_FLOOR_SPEED  8'h0f
`define MASK_FAN_FILTER_CTRL  8'hfd

// Duty scale and timing
`define DUTY_FULL             4'hf
`define PWM_SLOTS             15
`define MS_PER_SEC            1000
`define CENTI_PER_UNIT        100

// Spin-up durations in ms
`define SPIN_MS_0             14'h00c8
`define SPIN_MS_1             14'h0190
`define SPIN_MS_2             14'h0258
`define SPIN_MS_3             14'h0320
`define SPIN_MS_4             14'h03e8
`define SPIN_MS_5             14'h07d0
`define SPIN_MS_6             14'h0fa0
`define SPIN_MS_7             14'h1f40

// PWM frequencies in hundredths of a hertz
`define FREQ_CHZ_0            32'h0492
`define FREQ_CHZ_1            32'h0618
`define FREQ_CHZ_2            32'h0924
`define FREQ_CHZ_3            32'h0c35
`define FREQ_CHZ_4            32'h0ea6
`define FREQ_CHZ_5            32'h1252
`define FREQ_CHZ_6            32'h186a
`define FREQ_CHZ_7            32'h2486

`endif

// ---- core/fan_pkg.sv ----
package fan_pkg;
    typedef enum logic [1:0] {
        SPIN_STOPPED = 2'b00,
        SPIN_KICK    = 2'b01,
        SPIN_RUN     = 2'b10
    } spin_state_t;
endpackage

// ---- core/pwm_slot_gen.sv ----
`timescale 1ns/10ps
`include "fan_regs_map.svh"

module pwm_slot_gen #(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Timing
    input  wire logic [CNT_W-1:0] slot_cycles,
    input  wire logic [3:0]       duty,
    // Result
    output logic                  active,
    output logic                  period_end
);
    logic [CNT_W-1:0] cyc_q, cyc_d;
    logic [3:0]       slot_q, slot_d;
    logic             act_q, act_d;
    logic             end_q, end_d;

    always_comb begin
        cyc_d  = cyc_q + 1'b1;
        slot_d = slot_q;
        end_d  = 1'b0;
        if (cyc_q + 1'b1 >= slot_cycles) begin
            cyc_d = '0;
            if (slot_q == 4'(`PWM_SLOTS - 1)) begin
                slot_d = 4'h0;
                end_d  = 1'b1;
            end else begin
                slot_d = slot_q + 4'h1;
            end
        end
        act_d = (slot_d < duty);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cyc_q  <= '0;
            slot_q <= 4'h0;
            act_q  <= 1'b0;
            end_q  <= 1'b0;
        end else begin
            cyc_q  <= cyc_d;
            slot_q <= slot_d;
            act_q  <= act_d;
            end_q  <= end_d;
        end
    end

    assign active     = act_q;
    assign period_end = end_q;
endmodule

// ---- sim/fan_regs_assertions.sv ----
`timescale 1ns/10ps
module fan_regs_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Measurement and pin
    input wire logic       local_over_limit,
    input wire logic [2:0] remote_frac,
    input wire logic [1:0] local_frac,
    input wire logic       therm_n_in,
    // Fan side
    input wire logic [3:0] speed_range_n,
    input wire logic [2:0] adc_rate_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [1:0] range_code;
    logic [2:0] adc_code;
    assign range_code = reg_wdata[7:6];
    assign adc_code   = reg_wdata[4:2];

    a_fraction_read: assert property (reg_rd && reg_addr == 8'h06 |=>
        reg_rdata == {$past(local_frac), 3'h0, $past(remote_frac)})
        else $error("fraction read wrong");
    a_floor_upper: assert property (reg_rd && reg_addr == 8'h22 |=> reg_rdata[7:4] == 4'h0)
        else $error("floor upper bits not zero");
    a_filter_unused: assert property (reg_rd && reg_addr == 8'h23 |=> !reg_rdata[1])
        else $error("filter unused bit set");
    a_status_low: assert property (reg_rd && reg_addr == 8'h03 |=> reg_rdata[5:0] == 6'h00)
        else $error("status low bits set");
    a_unmapped_zero: assert property (reg_rd && !(reg_addr inside
        {8'h03, 8'h06, 8'h20, 8'h22, 8'h23}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_range_map: assert property (reg_wr && reg_addr == 8'h20 |->
        ##2 speed_range_n == 4'h1 << $past(range_code, 2))
        else $error("speed range divisor wrong");
    a_adc_map: assert property (reg_wr && reg_addr == 8'h23 |->
        ##2 adc_rate_sel == $past(adc_code, 2))
        else $error("sample rate code wrong");
    a_status_clear: assert property ((therm_n_in && $stable(local_over_limit))[*4] ##0
        (reg_rd && reg_addr == 8'h03) ##1 (reg_rd && reg_addr == 8'h03 && therm_n_in
        && $stable(local_over_limit)) |=> reg_rdata == 8'h00)
        else $error("status not cleared by read");
endmodule

bind fan_pwm_config_status_regs fan_regs_checker fan_regs_checker_i (
    .clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .local_over_limit, .remote_frac, .local_frac, .therm_n_in,
    .speed_range_n, .adc_rate_sel
);

// ---- sim/fan_host_model.sv ----
`timescale 1ns/10ps
module fan_host_model (
    // Bus
    input  wire logic [7:0] reg_rdata,
    input  wire logic       clk,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
        reg_addr = ~a;
    endtask
    // Two back-to-back reads of one address
    task automatic rd(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        d0 = reg_rdata;
        @(negedge clk);
        d1 = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

// ---- sim/fan_pwm_config_status_regs_test.sv ----
`timescale 1ns/10ps
module fan_pwm_config_status_regs_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d0, d1;
    logic        reg_wr, reg_rd, pwm_out;
    logic        local_over_limit = 1'b0;
    logic [2:0]  remote_frac = 3'h0;
    logic [1:0]  local_frac = 2'h0;
    logic [3:0]  auto_duty = 4'h0;
    logic        therm_n_in = 1'b1;
    logic        auto_control_select = 1'b0;
    logic        pwm_invert = 1'b0;
    logic [3:0]  speed_range_n;
    logic [2:0]  adc_rate_sel;
    int          mismatches = 0;
    int          check_count = 0;
    int          i, c;
    logic [23:0] rows [8] = '{24'h20ffff, 24'h200000, 24'h22ff0f, 24'h22a000,
                              24'h23fffd, 24'h230200, 24'h06ff85, 24'h10ff00};
    logic [15:0] rst_rows [5] = '{16'h205d, 16'h2205, 16'h2350, 16'h0300, 16'h0600};

    always #25 clk = ~clk;

    fan_pwm_config_status_regs #(.CLK_HZ(30000)) fan_pwm_config_status_regs_i (
        .clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .local_over_limit, .remote_frac, .local_frac, .auto_duty, .therm_n_in,
        .auto_control_select, .pwm_invert, .pwm_out, .speed_range_n, .adc_rate_sel
    );
    fan_host_model fan_host_model_i (
        .clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Active cycles of the fan output over n cycles
    task automatic count_on(input int n);
        c = 0;
        repeat (n) begin
            @(negedge clk);
            if ($isunknown(pwm_out)) begin
                c += 2000;
            end else begin
                c += (pwm_out == pwm_invert);
            end
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic pwm_is(input int n, input int exp);
        repeat (n) @(negedge clk);
        count_on(960);
        check(16'(c), 16'(exp));
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        complete_run;
    end

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        foreach (rst_rows[k]) begin
            fan_host_model_i.rd(rst_rows[k][15:8], d0, d1);
            check({8'h00, d0}, {8'h00, rst_rows[k][7:0]});
        end
        check({12'h000, speed_range_n}, 16'h0002);
        check({13'h0000, adc_rate_sel}, 16'h0004);
        local_frac = 2'h2;
        remote_frac = 3'h5;
        foreach (rows[k]) begin
            fan_host_model_i.wr(rows[k][23:16], rows[k][15:8]);
            fan_host_model_i.rd(rows[k][23:16], d0, d1);
            check({d0, d1}, {2{rows[k][7:0]}});
        end
        for (i = 0; i < 4; i++) begin
            fan_host_model_i.wr(8'h20, {i[1:0], 6'h18});
            @(negedge clk);
            check({12'h000, speed_range_n}, 16'h0001 << i);
        end
        for (i = 0; i < 8; i++) begin
            fan_host_model_i.wr(8'h23, {3'h4, i[2:0], 2'h0});
            @(negedge clk);
            check({13'h0000, adc_rate_sel}, 16'(i));
        end
        local_over_limit = 1'b1;
        repeat (5) @(negedge clk);
        fan_host_model_i.rd(8'h03, d0, d1);
        check({d0, d1}, 16'h4000);
        local_over_limit = 1'b0;
        therm_n_in = 1'b0;
        repeat (6) @(negedge clk);
        fan_host_model_i.rd(8'h03, d0, d1);
        check({d0, d1}, 16'h8000);
        fan_host_model_i.wr(8'h23, 8'h50);
        fan_host_model_i.wr(8'h20, 8'h18);
        pwm_is(1000, 960);
        pwm_invert = 1'b1;
        pwm_is(2, 960);
        pwm_invert = 1'b0;
        therm_n_in = 1'b1;
        pwm_is(1000, 0);
        fan_host_model_i.wr(8'h22, 8'h05);
        pwm_is(2000, 960);
        pwm_is(4000, 320);
        fan_host_model_i.wr(8'h22, 8'h00);
        repeat (1000) @(negedge clk);
        fan_host_model_i.wr(8'h23, 8'h90);
        fan_host_model_i.wr(8'h22, 8'h05);
        pwm_is(1000, 320);
        auto_control_select = 1'b1;
        auto_duty = 4'h2;
        pwm_is(1000, 320);
        auto_duty = 4'ha;
        pwm_is(1000, 640);
        auto_control_select = 1'b0;
        repeat (1000) @(negedge clk);
        fan_host_model_i.wr(8'h23, 8'h91);
        fan_host_model_i.wr(8'h22, 8'h0f);
        repeat (1000) @(negedge clk);
        count_on(960);
        check({15'h0000, c > 320 && c < 960}, 16'h0001);
        pwm_is(12000, 960);
        fan_host_model_i.wr(8'h23, 8'h90);
        fan_host_model_i.wr(8'h22, 8'h05);
        fan_host_model_i.wr(8'h20, 8'h38);
        repeat (1000) @(negedge clk);
        count_on(315);
        check(16'(c), 16'h0069);
        fan_host_model_i.wr(8'h23, 8'hf1);
        fan_host_model_i.wr(8'h22, 8'h0f);
        repeat (700) @(negedge clk);
        count_on(315);
        check(16'(c), 16'h013b);
        complete_run;
    end
endmodule
